// file: hdl/srwc_consts.svh
// constants for the standby release wait control block
`ifndef SRWC_CONSTS_SVH
`define SRWC_CONSTS_SVH
`define SRWC_OFF_WAIT_SEL 8'h00
`define SRWC_OFF_CLK_CTRL 8'h04
`define SRWC_OFF_STATUS 8'h08
`define SRWC_OFF_MASK 8'h0C
`define SRWC_OFF_CORE 8'h10
`define SRWC_WAIT_SEL_RST 4'h0
`define SRWC_CLK_CTRL_RST 4'h0
`define SRWC_BIT_HALT 2
`define SRWC_BIT_STOP 3
`define SRWC_CODE_W20 3'h0
`define SRWC_CODE_W17 3'h3
`define SRWC_CODE_W15 3'h5
`define SRWC_CODE_W13 3'h7
`define SRWC_EXP_W20 5'h14
`define SRWC_EXP_W17 5'h11
`define SRWC_EXP_W15 5'h0F
`define SRWC_EXP_W13 5'h0D
`define SRWC_OSC_START_CYC 16'h0100
`define SRWC_POST_INSTR 2'h2
`endif

// file: hdl/srwc_pkg.sv
// types for the standby release wait control block
package srwc_pkg;
  typedef enum logic [2:0] {
    SRWC_RUN = 3'b000,
    SRWC_HALT = 3'b001,
    SRWC_STOP = 3'b011,
    SRWC_OSC = 3'b010,
    SRWC_SETTLE = 3'b110,
    SRWC_RESUME = 3'b111
  } srwc_state_e;
  typedef struct packed {
    logic [7:0] pending;
    logic [7:0] enable;
    logic master_en;
  } srwc_irq_s;
  typedef struct packed {
    logic vector;
    logic from_reset;
    logic resume;
  } srwc_wake_s;
endpackage

// file: hdl/srwc_wait_counter.sv
// settling wait counter of main oscillator cycles
`timescale 1ns/1ps
module srwc_wait_counter
  import srwc_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // synced reset
  input wire logic start_in, // restart counting
  input wire logic run_in, // oscillator running
  input wire logic [4:0] exp_in, // count is 2**exp
  output logic done_out // count reached, pulse
);
  logic [20:0] count;
  logic [20:0] limit;
  assign limit = 21'(21'h1 << exp_in) - 21'h1;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      count <= 21'h0;
    else if (start_in || !run_in)
      count <= 21'h0;
    else if (count != limit)
      count <= count + 21'h1;
  end
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      done_out <= 1'b0;
    else
      done_out <= run_in && !start_in && (count == limit - 21'h1);
  end
endmodule

// file: hdl/srwc_top.sv
// standby release and settling wait control with ahb-lite registers
//
// Behaviour
// - interrupt stop release waits selected settling time
// - wait codes 000/011/101/111 give 2^20/17/15/13
// - count only once oscillator is running
// - reset stop release waits option-fixed time
// - reset release runs normal reset sequence
// - master enable clear: resume, keep request
// - master enable set: two instructions, vector
// - key edge or clock timer wake never vectors
// - stop sets clock ctrl bit3, halt bit2
// - reset or enabled request ends standby
// - halt gates cpu clock, stop kills oscillator
// - stop with pending request keeps oscillator on, still waits settling
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "srwc_consts.svh"
module srwc_top
  import srwc_pkg::*;
#(
  parameter bit LONG_RESET_WAIT = 1'b1, // 1: 2^17, 0: 2^15 (otp part)
  parameter logic [15:0] OSC_START_CYC = `SRWC_OSC_START_CYC
)
(
  input wire logic ref_clk_in, // main clock
  input wire logic rst_n_in, // async reset, low
  input wire logic hsel_in, // ahb select
  input wire logic [31:0] haddr_in, // ahb address
  input wire logic [1:0] htrans_in, // ahb transfer type
  input wire logic hwrite_in, // ahb write
  input wire logic [2:0] hsize_in, // ahb size
  input wire logic [31:0] hwdata_in, // ahb write data
  input wire logic hready_in, // ahb bus ready
  output logic [31:0] hrdata_out, // ahb read data
  output logic hreadyout_out, // ahb slave ready
  output logic hresp_out, // ahb response
  input wire logic stop_instr_in, // stop executed, pulse
  input wire logic halt_instr_in, // halt executed, pulse
  input wire logic instr_done_in, // instruction retired, pulse
  input wire logic [7:0] irq_pending_in, // request flags
  input wire logic [7:0] irq_enable_in, // enable flags
  input wire logic master_irq_enable_in, // master enable
  input wire logic key_edge_irq_in, // key edge source woke
  input wire logic clock_timer_irq_in, // clock timer source woke
  output logic cpu_clk_en_out, // cpu clock gate
  output logic osc_en_out, // main oscillator enable
  output logic core_reset_out, // core reset sequence
  output logic vector_req_out, // take vectored interrupt, pulse
  output logic irq_out // interrupt level
);
  logic rst_s1, rst_n;
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  function automatic logic [4:0] srwc_code_exp(input logic [2:0] code);
    unique case (code)
      `SRWC_CODE_W17: srwc_code_exp = `SRWC_EXP_W17;
      `SRWC_CODE_W15: srwc_code_exp = `SRWC_EXP_W15;
      `SRWC_CODE_W13: srwc_code_exp = `SRWC_EXP_W13;
      default: srwc_code_exp = `SRWC_EXP_W20;
    endcase
  endfunction

  srwc_state_e state, next_state;
  srwc_irq_s irq;
  srwc_wake_s wake;
  logic [3:0] wake_wait_select;
  logic [3:0] cpu_clock_ctrl;
  logic [2:0] status;
  logic [2:0] irq_mask;
  logic [15:0] osc_cnt;
  logic [1:0] instr_cnt;
  logic from_reset;
  logic wake_vector;
  logic osc_run, wait_done;
  logic [4:0] wait_exp;

  assign irq.pending = irq_pending_in;
  assign irq.enable = irq_enable_in;
  assign irq.master_en = master_irq_enable_in;

  // bus decode
  logic ap_valid, dp_valid, dp_write;
  logic [7:0] dp_addr;
  assign ap_valid = hsel_in && hready_in && htrans_in[1];
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end
    else
    begin
      dp_valid <= ap_valid;
      dp_write <= hwrite_in;
      dp_addr <= haddr_in[7:0];
    end
  end
  logic wr_en, rd_en, wr_wait, wr_clk, wr_mask, rd_status;
  assign wr_en = dp_valid && dp_write;
  assign rd_en = ap_valid && !hwrite_in;
  assign wr_wait = wr_en && dp_addr == `SRWC_OFF_WAIT_SEL;
  assign wr_clk = wr_en && dp_addr == `SRWC_OFF_CLK_CTRL;
  assign wr_mask = wr_en && dp_addr == `SRWC_OFF_MASK;
  assign rd_status = rd_en && haddr_in[7:0] == `SRWC_OFF_STATUS;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  // wake and events
  logic wake_req, stop_now, halt_now;
  logic ev_wake, ev_vector, ev_done;
  assign wake_req = |(irq.pending & irq.enable);
  assign wake_vector = irq.master_en && !key_edge_irq_in
    && !clock_timer_irq_in;
  assign stop_now = state == SRWC_RUN && stop_instr_in;
  assign halt_now = state == SRWC_RUN && halt_instr_in && !stop_instr_in;
  assign ev_wake = (state == SRWC_HALT || state == SRWC_STOP) && wake_req;
  assign ev_vector = vector_req_out;
  assign ev_done = state == SRWC_SETTLE && wait_done;
  assign osc_run = osc_cnt == OSC_START_CYC;
  assign wait_exp = from_reset
    ? (LONG_RESET_WAIT ? `SRWC_EXP_W17 : `SRWC_EXP_W15)
    : srwc_code_exp(wake_wait_select[2:0]);

  always_comb
  begin
    next_state = state;
    unique case (state)
      SRWC_RUN:
        if (stop_instr_in)
          next_state = wake_req ? SRWC_OSC : SRWC_STOP;
        else if (halt_instr_in)
          next_state = SRWC_HALT;
      SRWC_HALT:
        if (wake_req)
          next_state = SRWC_RESUME;
      SRWC_STOP:
        if (wake_req)
          next_state = SRWC_OSC;
      SRWC_OSC:
        if (osc_run)
          next_state = SRWC_SETTLE;
      SRWC_SETTLE:
        if (wait_done)
          next_state = SRWC_RESUME;
      SRWC_RESUME:
        next_state = SRWC_RUN;
      default:
        next_state = SRWC_RUN;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      state <= SRWC_OSC;
    else
      state <= next_state;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      from_reset <= 1'b1;
    else if (state == SRWC_RESUME)
      from_reset <= 1'b0;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      osc_cnt <= 16'h0000;
    else if (state == SRWC_STOP)
      osc_cnt <= 16'h0000;
    else if (!osc_run)
      osc_cnt <= osc_cnt + 16'h0001;
  end

  srwc_wait_counter u_wait
  (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .start_in(state != SRWC_SETTLE),
    .run_in(osc_run),
    .exp_in(wait_exp),
    .done_out(wait_done)
  );

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      wake_wait_select <= `SRWC_WAIT_SEL_RST;
    else if (wr_wait)
      wake_wait_select <= hwdata_in[3:0];
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      cpu_clock_ctrl <= `SRWC_CLK_CTRL_RST;
    else if (stop_now)
      cpu_clock_ctrl[`SRWC_BIT_STOP] <= 1'b1;
    else if (halt_now)
      cpu_clock_ctrl[`SRWC_BIT_HALT] <= 1'b1;
    else if (state == SRWC_RESUME)
      cpu_clock_ctrl[3:2] <= 2'b00;
    else if (wr_clk)
      cpu_clock_ctrl[1:0] <= hwdata_in[1:0];
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake <= '0;
      instr_cnt <= 2'h0;
      vector_req_out <= 1'b0;
    end
    else
    begin
      vector_req_out <= 1'b0;
      if (state == SRWC_RESUME)
      begin
        wake.resume <= 1'b1;
        wake.from_reset <= from_reset;
        wake.vector <= !from_reset && wake_vector;
        instr_cnt <= 2'h0;
      end
      else if (wake.vector && instr_done_in)
      begin
        if (instr_cnt == `SRWC_POST_INSTR - 2'h1)
        begin
          wake.vector <= 1'b0;
          vector_req_out <= 1'b1;
        end
        instr_cnt <= instr_cnt + 2'h1;
      end
    end
  end

  // sticky status, cleared by read
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      status <= 3'h0;
    else
      status <= (rd_status ? 3'h0 : status) | {ev_done, ev_vector, ev_wake};
  end
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask <= 3'h0;
    else if (wr_mask)
      irq_mask <= hwdata_in[2:0];
  end
  assign irq_out = |(status & irq_mask);

  logic [31:0] rd_mux;
  assign rd_mux =
    haddr_in[7:0] == `SRWC_OFF_WAIT_SEL ? {28'h0, wake_wait_select} :
    haddr_in[7:0] == `SRWC_OFF_CLK_CTRL ? {28'h0, cpu_clock_ctrl} :
    haddr_in[7:0] == `SRWC_OFF_STATUS ? {29'h0, status} :
    haddr_in[7:0] == `SRWC_OFF_MASK ? {29'h0, irq_mask} :
    haddr_in[7:0] == `SRWC_OFF_CORE ? {26'h0, state, wake} : 32'h0;
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      hrdata_out <= 32'h0;
    else if (rd_en)
      hrdata_out <= rd_mux;
  end

  assign cpu_clk_en_out = state == SRWC_RUN;
  assign osc_en_out = state != SRWC_STOP;
  // core held in reset until wait done
  assign core_reset_out = from_reset;
endmodule

// file: verification/srwc_assertions.sv
// assertions for the standby release wait control block
`timescale 1ns/1ps
module srwc_assertions
(
  input wire logic ref_clk_in, // clock
  input wire logic rst_n_in, // reset, low
  input wire logic stop_instr_in, // stop pulse
  input wire logic halt_instr_in, // halt pulse
  input wire logic instr_done_in, // retired
  input wire logic [7:0] irq_pending_in, // requests
  input wire logic [7:0] irq_enable_in, // enables
  input wire logic master_irq_enable_in, // master enable
  input wire logic key_edge_irq_in, // key source
  input wire logic clock_timer_irq_in, // timer source
  input wire logic hreadyout_out, // ready
  input wire logic hresp_out, // response
  input wire logic cpu_clk_en_out, // cpu gate
  input wire logic osc_en_out, // oscillator
  input wire logic core_reset_out, // core reset
  input wire logic vector_req_out // vector pulse
);
  default clocking
    @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence stop_idle;
    stop_instr_in && cpu_clk_en_out && !(|(irq_pending_in & irq_enable_in));
  endsequence
  sequence halt_idle;
    halt_instr_in && !stop_instr_in && cpu_clk_en_out
      && !(|(irq_pending_in & irq_enable_in));
  endsequence
  sequence osc_back;
    !osc_en_out ##1 osc_en_out;
  endsequence
  chk_stop_osc_off: assert property (stop_idle |=> !osc_en_out)
    else $error("stop left oscillator on");
  chk_halt_gate: assert property (
    halt_idle |=> !cpu_clk_en_out && osc_en_out)
    else $error("halt gating wrong");
  chk_settle_hold: assert property (
    osc_back |-> !cpu_clk_en_out [*8])
    else $error("cpu clock before settling");
  chk_no_osc_run: assert property (!osc_en_out |-> !cpu_clk_en_out)
    else $error("cpu clock without oscillator");
  chk_reset_gate: assert property (core_reset_out |-> !cpu_clk_en_out)
    else $error("cpu runs during reset wait");
  chk_vec_cause: assert property (
    vector_req_out |-> master_irq_enable_in
    && !key_edge_irq_in && !clock_timer_irq_in)
    else $error("vector without permission");
  chk_vec_after: assert property (
    vector_req_out |-> $past(instr_done_in))
    else $error("vector not after instruction");
  chk_vec_pulse: assert property (vector_req_out |=> !vector_req_out)
    else $error("vector longer than one cycle");
  chk_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus not ready or error");
endmodule
bind srwc_top srwc_assertions chk (.ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in), .stop_instr_in(stop_instr_in),
  .halt_instr_in(halt_instr_in), .instr_done_in(instr_done_in),
  .irq_pending_in(irq_pending_in), .irq_enable_in(irq_enable_in),
  .master_irq_enable_in(master_irq_enable_in),
  .key_edge_irq_in(key_edge_irq_in), .clock_timer_irq_in(clock_timer_irq_in),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .cpu_clk_en_out(cpu_clk_en_out), .osc_en_out(osc_en_out),
  .core_reset_out(core_reset_out), .vector_req_out(vector_req_out));

// file: verification/srwc_top_tb_top.sv
// self-checking bench for the standby release wait control block
`timescale 1ns/1ps
`include "srwc_consts.svh"
module srwc_top_tb_top;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, stp = 0, hlt = 0, dn = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [7:0] pend = 0, ena = 0;
  logic me = 0, key = 0, tmr = 0;
  logic rdy, resp, cpu_en, osc_en, core_rst, vec, irq;
  int fail_count = 0, checks = 0, n;
  always #5 clk = ~clk;
  srwc_top #(.LONG_RESET_WAIT(1'b0), .OSC_START_CYC(16'h0004)) DUT (
    .ref_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(rdy), .hrdata_out(hrdata),
    .hreadyout_out(rdy), .hresp_out(resp), .stop_instr_in(stp),
    .halt_instr_in(hlt), .instr_done_in(dn), .irq_pending_in(pend),
    .irq_enable_in(ena), .master_irq_enable_in(me), .key_edge_irq_in(key),
    .clock_timer_irq_in(tmr), .cpu_clk_en_out(cpu_en), .osc_en_out(osc_en),
    .core_reset_out(core_rst), .vector_req_out(vec), .irq_out(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // single ahb transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_cpu;
    n = 0;
    while (cpu_en !== 1'b1 && n < 40000)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic t_regs;
    bus(0, `SRWC_OFF_WAIT_SEL, 0);
    check(rd, 0);
    bus(1, `SRWC_OFF_WAIT_SEL, 32'hF);
    bus(0, `SRWC_OFF_WAIT_SEL, 0);
    check(rd, 32'hF);
    bus(1, `SRWC_OFF_CLK_CTRL, 32'hF);
    repeat (4) @(posedge clk);
    check(cpu_en, 1);
    bus(0, `SRWC_OFF_CLK_CTRL, 0);
    check(rd, 32'h3);
    bus(0, 8'h20, 0);
    check(rd, 0);
    $display("register test done");
  endtask
  task automatic t_halt(input logic m, k, t, mk);
    bus(1, `SRWC_OFF_MASK, {31'h0, mk});
    me <= m;
    key <= k;
    tmr <= t;
    ena <= 8'h01;
    hlt <= 1'b1;
    @(posedge clk);
    hlt <= 1'b0;
    pend <= 8'h02;
    repeat (5) @(posedge clk);
    check(cpu_en, 0);
    check(osc_en, 1);
    bus(0, `SRWC_OFF_CLK_CTRL, 0);
    check(rd[3:2], 2'h1);
    pend <= 8'h03;
    wait_cpu;
    check(n < 4, 1);
    dn <= 1'b1;
    repeat (2) @(posedge clk);
    dn <= 1'b0;
    @(posedge clk);
    check(vec, m && !k && !t);
    pend <= 8'h00;
    check(irq, mk);
    bus(0, `SRWC_OFF_STATUS, 0);
    check(rd[1:0], {m && !k && !t, 1'b1});
    check(irq, 0);
    $display("halt test done");
  endtask
  task automatic t_stop(input logic p);
    me <= 1'b0;
    pend <= {7'h0, p};
    stp <= 1'b1;
    @(posedge clk);
    stp <= 1'b0;
    @(posedge clk);
    check(osc_en, p);
    bus(0, `SRWC_OFF_CLK_CTRL, 0);
    check(rd[3:2], 2'h2);
    pend <= 8'h01;
    wait_cpu;
    check(n >= 8192 && n < 8220, 1);
    pend <= 8'h00;
    bus(0, `SRWC_OFF_STATUS, 0);
    check(rd[2:0], {2'b10, !p});
    $display("stop test done");
  endtask
  initial
  begin
    #600000;
    fail_count++;
    complete_run;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_cpu;
    check(n >= 32772 && n < 32800, 1);
    check(core_rst, 0);
    $display("reset test done");
    t_regs;
    t_halt(1, 0, 0, 1);
    t_halt(0, 0, 0, 0);
    t_halt(1, 1, 0, 1);
    t_halt(1, 0, 1, 1);
    t_stop(0);
    t_stop(1);
    complete_run;
  end
endmodule
